// file: tlbs_pkg.sv
// Constants and types shared by the trigger layer bypass sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package tlbs_pkg;
    // Trigger line count and widths
    localparam int          LINE_COUNT = 6;
    localparam int          LINE_W     = 3;
    localparam int          FIELD_W    = 2;
    // Layer indices
    localparam logic [1:0] LAYER_ARM  = 2'h0;
    localparam logic [1:0] LAYER_SCAN = 2'h1;
    localparam logic [1:0] LAYER_MEAS = 2'h2;
    // Configuration field codes
    localparam logic [1:0] FIELD_DIR   = 2'h0;
    localparam logic [1:0] FIELD_INPUT_LINE_SELECT = 2'h1;
    localparam logic [1:0] FIELD_OUTPUT_LINE_SELECT = 2'h2;
    localparam logic [1:0] FIELD_PROTO = 2'h3;
    // Direction codes: source enables bypass, bypass_off_value disables it
    localparam logic       DIR_SOURCE           = 1'h1;
    localparam logic       DIR_BYPASS_OFF_VALUE = 1'h0;
    // Reset and preset values
    localparam logic [2:0] INPUT_LINE_RESET  = 3'h2;
    localparam logic [2:0] OUTPUT_LINE_RESET = 3'h1;
    localparam logic       DIR_RESET         = DIR_BYPASS_OFF_VALUE;
    localparam logic       PROTO_RESET       = 1'h0;  // 0 separate lines, 1 shared line
    // Control source codes
    localparam logic [1:0] SRC_IMMEDIATE           = 2'h0;
    localparam logic [1:0] SRC_EXTERNAL            = 2'h1;
    localparam logic [1:0] SRC_TRIGGER_LINE_SOURCE = 2'h2;
    // Sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DELAY, ST_ACTION} tlbs_state_t;
endpackage : tlbs_pkg

// file: tlbs_cfg_if.sv
// Interface between the sequencer and one layer's setting store.
// Assumes one instance per layer, all on the sequencer clock.
`timescale 1ns/100ps
interface tlbs_cfg_if;
    logic       wrEn;
    logic [1:0] field;
    logic [2:0] data;
    logic       preset;
    logic       bypassOn;
    logic [2:0] inLine;
    logic [2:0] outLine;
    logic       reject;
    modport seq   (output wrEn, field, data, preset, input bypassOn, inLine, outLine, reject);
    modport layer (input wrEn, field, data, preset, output bypassOn, inLine, outLine, reject);
endinterface : tlbs_cfg_if

// file: tlbs_layer_cfg.sv
// Per-layer store of bypass direction and input and output line numbers.
// Assumes writes arrive as single-cycle strobes from the sequencer.
`timescale 1ns/100ps
module tlbs_layer_cfg (
    input  wire logic  clock,
    input  wire logic  reset,
    tlbs_cfg_if.layer  cfg
);
    logic       dir_q;
    logic [2:0] inLine_q;
    logic [2:0] outLine_q;
    wire        lineBad = (cfg.data == 3'h0) || (cfg.data > 3'(tlbs_pkg::LINE_COUNT));

    // Refuse a line already held by the other direction, or out of range
    assign cfg.reject = cfg.wrEn && (
        (cfg.field == tlbs_pkg::FIELD_INPUT_LINE_SELECT && (lineBad || cfg.data == outLine_q)) ||
        (cfg.field == tlbs_pkg::FIELD_OUTPUT_LINE_SELECT && (lineBad || cfg.data == inLine_q)) ||
        (cfg.field == tlbs_pkg::FIELD_DIR && cfg.data[2:1] != 2'h0));
    assign cfg.bypassOn = dir_q;
    assign cfg.inLine   = inLine_q;
    assign cfg.outLine  = outLine_q;

    // Settings; reset and preset restore defaults
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dir_q     <= tlbs_pkg::DIR_RESET;
            inLine_q  <= tlbs_pkg::INPUT_LINE_RESET;
            outLine_q <= tlbs_pkg::OUTPUT_LINE_RESET;
        end else if (cfg.preset) begin
            dir_q     <= tlbs_pkg::DIR_RESET;
            inLine_q  <= tlbs_pkg::INPUT_LINE_RESET;
            outLine_q <= tlbs_pkg::OUTPUT_LINE_RESET;
        end else if (cfg.wrEn && !cfg.reject) begin
            if (cfg.field == tlbs_pkg::FIELD_DIR) begin
                dir_q <= cfg.data[0];
            end else if (cfg.field == tlbs_pkg::FIELD_INPUT_LINE_SELECT) begin
                inLine_q <= cfg.data;
            end else if (cfg.field == tlbs_pkg::FIELD_OUTPUT_LINE_SELECT) begin
                outLine_q <= cfg.data;
            end
        end
    end
endmodule : tlbs_layer_cfg

// file: tlbs_sequencer.sv
// Three-layer trigger sequencer (arm, scan, measure) with source bypass.
// Assumes all inputs synchronous to clock; trigger lines are open-drain
// and resolved outside.
`timescale 1ns/100ps
module tlbs_sequencer #(
    parameter int CNT_W = 8,
    parameter int DLY_W = 16
) (
    input  wire logic               clock,
    input  wire logic               reset,
    input  wire logic               cfgWrite,
    input  wire logic [1:0]         cfgLayer,
    input  wire logic [1:0]         cfgField,
    input  wire logic [2:0]         cfgData,
    input  wire logic               presetReq,
    input  wire logic [1:0]         qryLayer,
    input  wire logic [1:0]         qryField,
    input  wire logic [5:0]         srcSel,
    input  wire logic [3*CNT_W-1:0] layerCount,
    input  wire logic [3*DLY_W-1:0] layerDelay,
    input  wire logic               startReq,
    input  wire logic               extTrig,
    input  wire logic               devDone,
    input  wire logic [5:0]         trigLineIn,
    output logic      [5:0]         trigLineOut,
    output logic      [5:0]         trigLineOe,
    output logic                    measurementCompleteOutput,
    output logic                    devStart,
    output logic                    cfgError,
    output logic      [2:0]         qryData,
    output logic                    seqBusy
);
    if (CNT_W < 1 || DLY_W < 1) begin : gBadParam
        $error("CNT_W and DLY_W must be at least one");
    end

    // Line number to one-hot line mask
    function automatic logic [5:0] lineMask(input logic [2:0] num);
        lineMask = 6'h00;
        for (int i = 0; i < tlbs_pkg::LINE_COUNT; i++) begin
            if (num == 3'(i + 1)) lineMask[i] = 1'b1;
        end
    endfunction : lineMask

    tlbs_cfg_if cfgBus[3] ();
    logic [2:0] bypassOn;
    logic [2:0] inLine  [3];
    logic [2:0] outLine [3];
    logic [2:0] rejectL;

    // One independent setting store per layer
    for (genvar g = 0; g < 3; g++) begin : gLayer
        assign cfgBus[g].wrEn   = cfgWrite && cfgLayer == 2'(g)
                                  && cfgField != tlbs_pkg::FIELD_PROTO;
        assign cfgBus[g].field  = cfgField;
        assign cfgBus[g].data   = cfgData;
        assign cfgBus[g].preset = presetReq;
        assign bypassOn[g] = cfgBus[g].bypassOn;
        assign inLine[g]   = cfgBus[g].inLine;
        assign outLine[g]  = cfgBus[g].outLine;
        assign rejectL[g]  = cfgBus[g].reject;
        tlbs_layer_cfg uCfg (
            .clock (clock),
            .reset (reset),
            .cfg   (cfgBus[g])
        );
    end

    tlbs_pkg::tlbs_state_t state_q, state_d;
    logic [1:0]       layer_q, layer_d;
    logic [2:0]       first_q, first_d;
    logic [CNT_W-1:0] pass_q [3];
    logic [CNT_W-1:0] pass_d [3];
    logic [DLY_W-1:0] dly_q, dly_d;
    logic             proto_q;
    logic             fire;
    logic [1:0]       fireLayer;
    logic             advance;
    logic             devStart_d;

    // Current layer's selections
    wire [1:0]       srcCur   = srcSel[layer_q*2 +: 2];
    wire [DLY_W-1:0] delayCur = layerDelay[layer_q*DLY_W +: DLY_W];
    wire [CNT_W-1:0] cntArm   = layerCount[0 +: CNT_W];
    wire [CNT_W-1:0] cntScan  = layerCount[CNT_W +: CNT_W];
    wire [CNT_W-1:0] cntMeas  = layerCount[2*CNT_W +: CNT_W];
    wire             layerOk  = layer_q <= tlbs_pkg::LAYER_MEAS;
    wire [2:0]       inCur    = layerOk ? inLine[layer_q] : tlbs_pkg::INPUT_LINE_RESET;

    // Source readiness and bypass decision
    wire srcReady = (srcCur == tlbs_pkg::SRC_IMMEDIATE) ||
                    (srcCur == tlbs_pkg::SRC_EXTERNAL && extTrig) ||
                    (srcCur == tlbs_pkg::SRC_TRIGGER_LINE_SOURCE
                     && |(trigLineIn & lineMask(inCur)));
    wire skip     = layerOk && bypassOn[layer_q] && first_q[layer_q]
                    && srcCur != tlbs_pkg::SRC_IMMEDIATE;
    wire goNow    = srcReady || skip;
    wire skipDly  = skip && layer_q != tlbs_pkg::LAYER_ARM;

    // Output routing for the layer that fires
    wire [1:0] fireSrc   = srcSel[fireLayer*2 +: 2];
    wire       fireShare = proto_q && fireLayer == tlbs_pkg::LAYER_MEAS;
    wire [2:0] fireLine  = (fireLayer > tlbs_pkg::LAYER_MEAS) ? tlbs_pkg::OUTPUT_LINE_RESET
                         : fireShare ? inLine[fireLayer] : outLine[fireLayer];
    wire       toLine    = fire && fireSrc == tlbs_pkg::SRC_TRIGGER_LINE_SOURCE;
    wire [5:0] lineOut_d = toLine ? lineMask(fireLine) : 6'h00;

    // Query and error selection
    wire       cfgBad   = cfgWrite && (cfgField == tlbs_pkg::FIELD_PROTO ? cfgData[2:1] != 2'h0
                          : (cfgLayer > tlbs_pkg::LAYER_MEAS || rejectL[cfgLayer]));
    wire       qryOk    = qryLayer <= tlbs_pkg::LAYER_MEAS;
    wire [2:0] qryDir   = {2'h0, qryOk && bypassOn[qryLayer]};
    wire [2:0] qry_d    = (qryField == tlbs_pkg::FIELD_PROTO) ? {2'h0, proto_q}
                        : !qryOk ? 3'h0
                        : (qryField == tlbs_pkg::FIELD_DIR) ? qryDir
                        : (qryField == tlbs_pkg::FIELD_INPUT_LINE_SELECT) ? inLine[qryLayer]
                        : outLine[qryLayer];

    // Next-state logic for the nested layers
    always_comb begin
        state_d    = state_q;
        layer_d    = layer_q;
        first_d    = first_q;
        pass_d     = pass_q;
        dly_d      = dly_q;
        fire       = 1'b0;
        fireLayer  = layer_q;
        advance    = 1'b0;
        devStart_d = 1'b0;
        case (state_q)
            tlbs_pkg::ST_IDLE: begin
                if (startReq) begin
                    state_d                     = tlbs_pkg::ST_WAIT;
                    layer_d                     = tlbs_pkg::LAYER_ARM;
                    first_d[tlbs_pkg::LAYER_ARM] = 1'b1;
                    pass_d[0]                   = CNT_W'(1);
                end
            end
            tlbs_pkg::ST_WAIT: begin
                if (goNow) begin
                    first_d[layer_q] = 1'b0;
                    if (!skipDly && layer_q != tlbs_pkg::LAYER_ARM && delayCur != '0) begin
                        state_d = tlbs_pkg::ST_DELAY;
                        dly_d   = delayCur - DLY_W'(1);
                    end else begin
                        advance = 1'b1;
                    end
                end
            end
            tlbs_pkg::ST_DELAY: begin
                if (dly_q == '0) begin
                    advance = 1'b1;
                end else begin
                    dly_d = dly_q - DLY_W'(1);
                end
            end
            tlbs_pkg::ST_ACTION: begin
                if (devDone) begin
                    fire      = 1'b1;
                    fireLayer = tlbs_pkg::LAYER_MEAS;
                    state_d   = tlbs_pkg::ST_WAIT;
                    if (pass_q[2] < cntMeas) begin
                        pass_d[2] = pass_q[2] + CNT_W'(1);
                    end else if (pass_q[1] < cntScan) begin
                        pass_d[1] = pass_q[1] + CNT_W'(1);
                        layer_d   = tlbs_pkg::LAYER_SCAN;
                    end else if (pass_q[0] < cntArm) begin
                        pass_d[0] = pass_q[0] + CNT_W'(1);
                        layer_d   = tlbs_pkg::LAYER_ARM;
                    end else begin
                        state_d = tlbs_pkg::ST_IDLE;
                    end
                end
            end
            default: state_d = tlbs_pkg::ST_IDLE;
        endcase
        // Leaving a layer downward; arm and scan pulse only when bypass is on
        if (advance) begin
            if (layer_q == tlbs_pkg::LAYER_MEAS) begin
                state_d    = tlbs_pkg::ST_ACTION;
                devStart_d = 1'b1;
            end else begin
                fire       = layerOk && bypassOn[layer_q];
                layer_d    = layer_q + 2'h1;
                state_d    = tlbs_pkg::ST_WAIT;
                first_d[layer_d] = 1'b1;
                pass_d[layer_d]  = CNT_W'(1);
            end
        end
    end

    // Sequencer state
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            state_q <= tlbs_pkg::ST_IDLE;
            layer_q <= tlbs_pkg::LAYER_ARM;
            first_q <= 3'h0;
            pass_q  <= '{default: '0};
            dly_q   <= '0;
        end else begin
            state_q <= state_d;
            layer_q <= layer_d;
            first_q <= first_d;
            pass_q  <= pass_d;
            dly_q   <= dly_d;
        end
    end

    // Protocol setting, shared by all layers but used by measure only
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            proto_q <= tlbs_pkg::PROTO_RESET;
        end else if (presetReq) begin
            proto_q <= tlbs_pkg::PROTO_RESET;
        end else if (cfgWrite && cfgField == tlbs_pkg::FIELD_PROTO && !cfgBad) begin
            proto_q <= cfgData[0];
        end
    end

    // Registered outputs
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            trigLineOut               <= 6'h00;
            trigLineOe                <= 6'h00;
            measurementCompleteOutput <= 1'b0;
            devStart                  <= 1'b0;
            cfgError                  <= 1'b0;
            qryData                   <= 3'h0;
            seqBusy                   <= 1'b0;
        end else begin
            trigLineOut               <= lineOut_d;
            trigLineOe                <= lineOut_d;
            measurementCompleteOutput <= fire && !toLine;
            devStart                  <= devStart_d;
            cfgError                  <= cfgBad;
            qryData                   <= qry_d;
            seqBusy                   <= state_d != tlbs_pkg::ST_IDLE;
        end
    end
endmodule : tlbs_sequencer

// file: tlbs_ext_model.sv
// Far-side instrument: answers device starts and fires trigger lines.
// Assumes the bench raises fireLine for as long as an event should last.
`timescale 1ns/100ps
module tlbs_ext_model #(
    parameter int DONE_LAT = 3
) (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       devStart,
    input  wire logic [5:0] fireLine,
    input  wire logic [5:0] trigLineOut,
    input  wire logic [5:0] trigLineOe,
    output logic      [5:0] trigLineIn,
    output logic            devDone
);
    logic [7:0] lat_q;
    // Wired lines: any enabled driver pulls a line to the event level
    assign trigLineIn = fireLine | (trigLineOut & trigLineOe);
    // Device action ends a fixed latency after its start
    always_ff @(posedge clock or posedge reset) begin
        if (reset) lat_q <= 8'h00;
        else if (devStart) lat_q <= 8'(DONE_LAT);
        else if (lat_q != 8'h00) lat_q <= lat_q - 8'h01;
    end
    assign devDone = (lat_q == 8'h01);
endmodule : tlbs_ext_model

// file: tlbs_sequencer_asserts.sv
// Port checker for the sequencer: settings refusal and walk timing.
// Assumes one clock domain and an active high asynchronous reset.
`timescale 1ns/100ps
module tlbs_sequencer_asserts #(
    parameter int CNT_W = 8,
    parameter int DLY_W = 16
) (
    input  wire logic               clock,
    input  wire logic               reset,
    input  wire logic               cfgWrite,
    input  wire logic [1:0]         cfgLayer,
    input  wire logic [1:0]         cfgField,
    input  wire logic [2:0]         cfgData,
    input  wire logic               presetReq,
    input  wire logic [5:0]         srcSel,
    input  wire logic [3*DLY_W-1:0] layerDelay,
    input  wire logic               startReq,
    input  wire logic               devDone,
    input  wire logic [5:0]         trigLineOut,
    input  wire logic [5:0]         trigLineOe,
    input  wire logic               measurementCompleteOutput,
    input  wire logic               devStart,
    input  wire logic               cfgError,
    input  wire logic               seqBusy
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // Write taken without a competing preset
    wire wrOk = cfgWrite && !presetReq;
    wire lineFld = cfgField == tlbs_pkg::FIELD_INPUT_LINE_SELECT || cfgField == tlbs_pkg::FIELD_OUTPUT_LINE_SELECT;
    // Steps of a measure action and of a plain walk
    sequence s_action;
        devStart ##[1:20] devDone;
    endsequence
    sequence s_walk;
        !seqBusy && startReq && srcSel == 6'h00 && layerDelay == '0;
    endsequence
    a_layer_refused: assert property (wrOk && cfgLayer == 2'h3 |=> cfgError)
        else $error("write to missing layer not refused");
    a_line_range: assert property (wrOk && cfgLayer != 2'h3 && lineFld
        && (cfgData == 3'h0 || cfgData == 3'h7) |=> cfgError)
        else $error("line out of range not refused");
    a_proto_range: assert property (wrOk && cfgField == tlbs_pkg::FIELD_PROTO
        && cfgData > 3'h1 |=> cfgError) else $error("bad protocol code not refused");
    a_dir_taken: assert property (wrOk && cfgLayer != 2'h3
        && cfgField == tlbs_pkg::FIELD_DIR && cfgData <= 3'h1 |=> !cfgError)
        else $error("valid direction write refused");
    a_err_cause: assert property (!cfgWrite |=> !cfgError)
        else $error("error pulse without a write");
    a_oe_tracks: assert property (trigLineOe == trigLineOut)
        else $error("line enable differs from line pulse");
    a_meas_pulse: assert property (s_action |=> measurementCompleteOutput || |trigLineOut)
        else $error("no pulse after device action");
    a_walk_time: assert property (s_walk |-> ##4 devStart)
        else $error("immediate walk not at device start in time");
    a_start_busy: assert property (devStart |-> seqBusy)
        else $error("device start while idle");
endmodule : tlbs_sequencer_asserts

bind tlbs_sequencer tlbs_sequencer_asserts #(.CNT_W(CNT_W), .DLY_W(DLY_W))
    i_tlbs_sequencer_asserts (.clock, .reset, .cfgWrite, .cfgLayer, .cfgField, .cfgData,
    .presetReq, .srcSel, .layerDelay, .startReq, .devDone, .trigLineOut, .trigLineOe,
    .measurementCompleteOutput, .devStart, .cfgError, .seqBusy);

// file: tlbs_sequencer_tb.sv
// Bench for the sequencer: settings, queries and trigger walks.
// Assumes the far-side model answers device starts and resolves lines.
`timescale 1ns/100ps
module tlbs_sequencer_tb;
    logic        clock      = 1'b0;
    logic        reset      = 1'b1;
    logic        cfgWrite   = 1'b0;
    logic [1:0]  cfgLayer   = 2'h0;
    logic [1:0]  cfgField   = 2'h0;
    logic [2:0]  cfgData    = 3'h0;
    logic        presetReq  = 1'b0;
    logic [1:0]  qryLayer   = 2'h0;
    logic [1:0]  qryField   = 2'h0;
    logic [5:0]  srcSel     = 6'h00;
    logic [23:0] layerCount = 24'h010101;
    logic [47:0] layerDelay = 48'h0;
    logic        startReq   = 1'b0;
    logic        extTrig    = 1'b0;
    logic [5:0]  fireLine   = 6'h00;
    logic [5:0]  trigLineIn, trigLineOut, trigLineOe, lineSeen;
    logic        mco, devStart, devDone, cfgError, seqBusy;
    logic [2:0]  qryData;
    int          fails      = 0;
    int          cmp_count  = 0;
    int          mcoCnt, lineCnt, devCnt;
    always #50 clock = ~clock;
    tlbs_sequencer i_tlbs_sequencer (.clock, .reset, .cfgWrite, .cfgLayer, .cfgField,
        .cfgData, .presetReq, .qryLayer, .qryField, .srcSel, .layerCount, .layerDelay,
        .startReq, .extTrig, .devDone, .trigLineIn, .trigLineOut, .trigLineOe,
        .measurementCompleteOutput(mco), .devStart, .cfgError, .qryData, .seqBusy);
    tlbs_ext_model i_tlbs_ext_model (.clock, .reset, .devStart, .fireLine, .trigLineOut,
        .trigLineOe, .trigLineIn, .devDone);
    // Pulse counters sampled between edges
    always @(negedge clock) begin
        if (mco === 1'b1) mcoCnt++;
        if ((|trigLineOut) === 1'b1) lineCnt++;
        if (devStart === 1'b1) devCnt++;
        lineSeen |= trigLineOut;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One setting write, refusal flag seen the cycle after
    task automatic cfg(input logic [1:0] l, f, input logic [2:0] d, input logic e);
        @(negedge clock);
        {cfgWrite, cfgLayer, cfgField, cfgData} = {1'b1, l, f, d};
        @(negedge clock);
        cfgWrite = 1'b0;
        check({7'h00, cfgError}, {7'h00, e});
    endtask : cfg
    task automatic qry(input logic [1:0] l, f, input logic [2:0] e);
        @(negedge clock);
        {qryLayer, qryField} = {l, f};
        @(negedge clock);
        check({5'h00, qryData}, {5'h00, e});
    endtask : qry
    task automatic preset;
        @(negedge clock);
        presetReq = 1'b1;
        @(negedge clock);
        presetReq = 1'b0;
    endtask : preset
    task automatic defaults;
        for (int l = 0; l < 3; l++) begin
            qry(2'(l), tlbs_pkg::FIELD_DIR, 3'h0);
            qry(2'(l), tlbs_pkg::FIELD_INPUT_LINE_SELECT, 3'h2);
            qry(2'(l), tlbs_pkg::FIELD_OUTPUT_LINE_SELECT, 3'h1);
        end
        qry(2'h0, tlbs_pkg::FIELD_PROTO, 3'h0);
    endtask : defaults
    task automatic start;
        @(negedge clock);
        {mcoCnt, lineCnt, devCnt, lineSeen} = '0;
        startReq = 1'b1;
        @(negedge clock);
        startReq = 1'b0;
    endtask : start
    // Wait for idle under a bound, then compare pulse totals
    task automatic finish(input int lim, input logic [7:0] eMco, eLine, eSeen);
        int n;
        n = 0;
        while (seqBusy === 1'b1 && n < lim) begin
            @(negedge clock);
            n++;
        end
        repeat (2) @(negedge clock);
        check({7'h00, seqBusy}, 8'h00);
        check(8'(mcoCnt), eMco);
        check(8'(lineCnt), eLine);
        check({2'h0, lineSeen}, eSeen);
    endtask : finish
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    // Watchdog well beyond the expected run length
    initial begin
        #3000000;
        fails++;
        complete_run();
    end
    // Test sequence
    initial begin
        repeat (6) @(negedge clock);
        reset = 1'b0;
        defaults();
        $display("test defaults done");
        cfg(2'h0, tlbs_pkg::FIELD_INPUT_LINE_SELECT, 3'h1, 1'b1);
        qry(2'h0, tlbs_pkg::FIELD_INPUT_LINE_SELECT, 3'h2);
        cfg(2'h0, tlbs_pkg::FIELD_INPUT_LINE_SELECT, 3'h7, 1'b1);
        cfg(2'h0, tlbs_pkg::FIELD_INPUT_LINE_SELECT, 3'h6, 1'b0);
        cfg(2'h1, tlbs_pkg::FIELD_OUTPUT_LINE_SELECT, 3'h2, 1'b1);
        cfg(2'h2, tlbs_pkg::FIELD_DIR, 3'h1, 1'b0);
        cfg(2'h3, tlbs_pkg::FIELD_DIR, 3'h1, 1'b1);
        cfg(2'h0, tlbs_pkg::FIELD_PROTO, 3'h2, 1'b1);
        qry(2'h2, tlbs_pkg::FIELD_DIR, 3'h1);
        qry(2'h0, tlbs_pkg::FIELD_INPUT_LINE_SELECT, 3'h6);
        qry(2'h1, tlbs_pkg::FIELD_DIR, 3'h0);
        preset();
        defaults();
        $display("test settings done");
        start();
        finish(40, 8'h01, 8'h00, 8'h00);
        $display("test plain walk done");
        cfg(2'h0, tlbs_pkg::FIELD_DIR, 3'h1, 1'b0);
        cfg(2'h1, tlbs_pkg::FIELD_DIR, 3'h1, 1'b0);
        start();
        finish(40, 8'h03, 8'h00, 8'h00);
        $display("test bypass pulses done");
        preset();
        srcSel = 6'h02;  // Arm waits on trigger line
        start();
        repeat (20) @(negedge clock);
        check(8'(devCnt), 8'h00);
        fireLine = 6'h02;
        @(negedge clock);
        fireLine = 6'h00;
        finish(40, 8'h01, 8'h00, 8'h00);
        $display("test bypass off wait done");
        cfg(2'h0, tlbs_pkg::FIELD_DIR, 3'h1, 1'b0);
        cfg(2'h1, tlbs_pkg::FIELD_DIR, 3'h1, 1'b0);
        srcSel = 6'h06;  // Arm trigger line, scan external
        layerDelay = 48'h0000_0032_0000;
        start();
        finish(15, 8'h02, 8'h01, 8'h01);
        $display("test bypass skip done");
        preset();
        cfg(2'h1, tlbs_pkg::FIELD_DIR, 3'h1, 1'b0);
        srcSel = 6'h04;
        layerDelay = 48'h0;
        layerCount = 24'h010201;
        start();
        repeat (30) @(negedge clock);
        check(8'(devCnt), 8'h01);
        extTrig = 1'b1;
        finish(60, 8'h04, 8'h00, 8'h00);
        extTrig = 1'b0;
        $display("test repeat pass done");
        preset();
        cfg(2'h0, tlbs_pkg::FIELD_PROTO, 3'h1, 1'b0);
        qry(2'h3, tlbs_pkg::FIELD_PROTO, 3'h1);
        srcSel = 6'h20;  // Measure waits on its input line
        layerCount = 24'h010101;
        start();
        repeat (10) @(negedge clock);
        check(8'(devCnt), 8'h00);
        fireLine = 6'h02;
        @(negedge clock);
        fireLine = 6'h00;
        finish(40, 8'h00, 8'h01, 8'h02);
        $display("test shared line done");
        complete_run();
    end
endmodule : tlbs_sequencer_tb
